/* File: hw/charger_option_two_control.sv */
`timescale 1ns/1ps
// What this block does
// - Overload time field selects 1, 2, 10 or 20 ms; resets to 00.
// - Bit 13 lets input current overshoot start peak power mode.
// - Bit 12 lets system rail undershoot start peak power mode.
// - Both trigger enables zero keeps peak power mode fully off.
// - Adapter removal clears both trigger enables.
// - Overload flag reads one during overload; writing zero exits it.
// - Relax flag reads one during relaxation; writing zero exits it.
// - Cycle field selects 5, 10, 20 or 40 ms period; resets to 10.
// - Overload longer than the period leaves no relax interval.
// - Bit 7 picks register limit alone or lower of pin and register.
// - Bit 6 picks discharge or charge current on the battery monitor.
// - Bit 5 picks 300 or 500 mV low-side switch trip.
// - Bit 4 picks 150 or 280 mV input trip.
// - Input overcurrent held past 100 us blanking disables converter when enabled.
// - Discharge overcurrent enable makes a discharge event disable the converter.
// - Bit 0 picks 125 or 200 percent of the throttle-alert discharge limit.
module charger_option_two_control
	import opt2_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P  = TICK_CYCLES,
	parameter int unsigned BLANK_CYCLES_P = BLANK_CYCLES
) (
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	input  wire logic [7:0]   reg_addr,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [15:0]  reg_wdata,
	output logic      [15:0]  reg_rdata,
	input  wire logic         adapter_present,
	input  wire logic         input_overshoot,
	input  wire logic         rail_sag,
	input  wire logic         input_oc_event,
	input  wire logic         discharge_oc_event,
	input  wire limit_t       limit_pin,
	input  wire limit_t       limit_reg,
	output limit_t            input_current_limit,
	output opt2_s             cfg_out,
	output logic              burst_overload,
	output logic              burst_relax,
	output logic              converter_off
);

////////////////////////////////////////////////////////////////////////////////
	// Register access.

	opt2_s  cfg_q;
	opt2_s  cfg_d;
	opt2_s  wr_view;
	burst_e state_q;
	burst_e state_d;
	logic   adapter_q;

	wire wr_hit    = reg_wr && (reg_addr == OPT2_ADDR);
	wire rd_hit    = reg_rd && (reg_addr == OPT2_ADDR);
	wire removal   = adapter_q && !adapter_present;
	wire clr_ovld  = wr_hit && !wr_view.overload_cycle_flag;
	wire clr_relax = wr_hit && !wr_view.relax_cycle_flag;

	assign wr_view = opt2_s'(reg_wdata);

	// Status flags are not stored; they always mirror the sequencer.
	opt2_s rd_view;
	always_comb begin
		rd_view                     = cfg_q;
		rd_view.overload_cycle_flag = (state_q == BURST_OVLD);
		rd_view.relax_cycle_flag    = (state_q == BURST_RELAX);
	end

	always_comb begin
		cfg_d = cfg_q;
		if (wr_hit) begin
			cfg_d = wr_view;
		end
		cfg_d.overload_cycle_flag = 1'b0;
		cfg_d.relax_cycle_flag    = 1'b0;
		// Removal wins over a host write in the same cycle.
		if (removal) begin
			cfg_d.burst_on_input_overshoot_en = 1'b0;
			cfg_d.burst_on_rail_sag_en        = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q     <= opt2_s'(OPT2_RESET);
			adapter_q <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			adapter_q <= adapter_present;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) reg_rdata <= '0;
		else if (reg_rd) reg_rdata <= rd_hit ? 16'(rd_view) : 16'h0000;
	end

////////////////////////////////////////////////////////////////////////////////
	// Peak power sequencer.

	tick_t cnt_q;
	tick_t cnt_d;
	logic  tick;

	wire   allowed  = cfg_q.burst_on_input_overshoot_en || cfg_q.burst_on_rail_sag_en;
	wire   trig     = (cfg_q.burst_on_input_overshoot_en && input_overshoot) ||
	                  (cfg_q.burst_on_rail_sag_en && rail_sag);
	wire   tick_t ovld_len  = ovld_ticks(cfg_q.overload_time_sel);
	wire   tick_t cycle_len = cycle_ticks(cfg_q.burst_cycle_period_sel);
	wire   no_relax = (ovld_len >= cycle_len);
	wire   tick_t relax_len = cycle_len - ovld_len;
	wire   tick_t cur_len   = (state_q == BURST_OVLD) ? ovld_len : relax_len;
	wire   seg_end  = tick && (cnt_q == cur_len - tick_t'(1));
	wire   restart  = (state_d != state_q) || seg_end;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			BURST_IDLE: begin
				if (allowed && trig) state_d = BURST_OVLD;
			end
			BURST_OVLD: begin
				if (!allowed || clr_ovld) state_d = BURST_IDLE;
				else if (seg_end) begin
					if (!no_relax) state_d = BURST_RELAX;
					else if (!trig) state_d = BURST_IDLE;
				end
			end
			BURST_RELAX: begin
				if (!allowed || clr_relax) state_d = BURST_IDLE;
				else if (seg_end) state_d = trig ? BURST_OVLD : BURST_IDLE;
			end
			default: state_d = BURST_IDLE;
		endcase
	end

	assign cnt_d = restart ? tick_t'(0) : (tick ? cnt_q + tick_t'(1) : cnt_q);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= BURST_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	tick_gen #(
		.PERIOD  (TICK_CYCLES_P)
	) u_tick (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.restart (restart),
		.tick    (tick)
	);

	assign burst_overload = (state_q == BURST_OVLD);
	assign burst_relax    = (state_q == BURST_RELAX);

////////////////////////////////////////////////////////////////////////////////
	// Limit selection and protection.

	logic ac_trip;
	oc_blanker #(
		.HOLD    (BLANK_CYCLES_P)
	) u_blank (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.oc_in   (input_oc_event),
		.trip    (ac_trip)
	);

	wire limit_t lower_limit = (limit_pin < limit_reg) ? limit_pin : limit_reg;
	wire limit_t limit_sel   = cfg_q.pin_limit_select ? lower_limit : limit_reg;
	wire         off_d       = (cfg_q.input_overcurrent_en && ac_trip) ||
	                           (cfg_q.discharge_overcurrent_en && discharge_oc_event);

	// The trip level bits reach the analog side through cfg_out unchanged.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			input_current_limit <= '0;
			converter_off       <= 1'b0;
			cfg_out             <= opt2_s'(OPT2_RESET);
		end else begin
			input_current_limit <= limit_sel;
			converter_off       <= off_d;
			cfg_out             <= rd_view;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_one_flag;
		@(posedge ref_clk) disable iff (!resetn) !(burst_overload && burst_relax);
	endproperty
	a_one_flag: assert property (p_one_flag) else $error("both flags set");

	property p_off_when_disabled;
		@(posedge ref_clk) disable iff (!resetn) !allowed |=> state_q == BURST_IDLE;
	endproperty
	a_off_when_disabled: assert property (p_off_when_disabled) else $error("burst while disabled");

	property p_removal;
		@(posedge ref_clk) disable iff (!resetn)
			removal |=> !cfg_q.burst_on_input_overshoot_en && !cfg_q.burst_on_rail_sag_en;
	endproperty
	a_removal: assert property (p_removal) else $error("enables kept after removal");

	property p_exit_ovld;
		@(posedge ref_clk) disable iff (!resetn) burst_overload && clr_ovld |=> !burst_overload;
	endproperty
	a_exit_ovld: assert property (p_exit_ovld) else $error("overload not left");

	property p_exit_relax;
		@(posedge ref_clk) disable iff (!resetn) burst_relax && clr_relax |=> !burst_relax;
	endproperty
	a_exit_relax: assert property (p_exit_relax) else $error("relax not left");

	property p_no_relax;
		@(posedge ref_clk) disable iff (!resetn) burst_overload && no_relax |=> !burst_relax;
	endproperty
	a_no_relax: assert property (p_no_relax) else $error("relax with long overload");

	property p_flag_read;
		@(posedge ref_clk) disable iff (!resetn)
			rd_hit |=> reg_rdata[11] == $past(burst_overload) && reg_rdata[10] == $past(burst_relax);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

	property p_limit;
		@(posedge ref_clk) disable iff (!resetn)
			!cfg_q.pin_limit_select |=> input_current_limit == $past(limit_reg);
	endproperty
	a_limit: assert property (p_limit) else $error("limit not from register");

	property p_batoc;
		@(posedge ref_clk) disable iff (!resetn)
			cfg_q.discharge_overcurrent_en && discharge_oc_event |=> converter_off;
	endproperty
	a_batoc: assert property (p_batoc) else $error("discharge trip missed");

	property p_acoc;
		@(posedge ref_clk) disable iff (!resetn)
			converter_off && !$past(discharge_oc_event) |-> $past(input_oc_event);
	endproperty
	a_acoc: assert property (p_acoc) else $error("converter off without cause");

	property p_enter;
		@(posedge ref_clk) disable iff (!resetn)
			!burst_overload && !burst_relax && trig |=> burst_overload;
	endproperty
	a_enter: assert property (p_enter) else $error("trigger did not start overload");

	property p_to_relax;
		@(posedge ref_clk) disable iff (!resetn)
			burst_overload && seg_end && !no_relax && allowed && !clr_ovld |=> burst_relax;
	endproperty
	a_to_relax: assert property (p_to_relax) else $error("relax interval skipped");

	property p_write;
		@(posedge ref_clk) disable iff (!resetn)
			wr_hit |=> cfg_q.overload_time_sel == $past(wr_view.overload_time_sel) &&
				cfg_q.burst_cycle_period_sel == $past(wr_view.burst_cycle_period_sel);
	endproperty
	a_write: assert property (p_write) else $error("period fields not written");

	property p_lower_limit;
		@(posedge ref_clk) disable iff (!resetn)
			cfg_q.pin_limit_select |=> input_current_limit <= $past(limit_pin) &&
				input_current_limit <= $past(limit_reg);
	endproperty
	a_lower_limit: assert property (p_lower_limit) else $error("limit too high");

	property p_lvl;
		@(posedge ref_clk) disable iff (!resetn)
			cfg_out.monitor_direction_sel == $past(cfg_q.monitor_direction_sel) &&
			cfg_out.low_switch_trip_sel == $past(cfg_q.low_switch_trip_sel) &&
			cfg_out.input_trip_sel == $past(cfg_q.input_trip_sel) &&
			cfg_out.input_overcurrent_level == $past(cfg_q.input_overcurrent_level) &&
			cfg_out.discharge_overcurrent_level == $past(cfg_q.discharge_overcurrent_level);
	endproperty
	a_lvl: assert property (p_lvl) else $error("levels lost");

	property p_off_cause;
		@(posedge ref_clk) disable iff (!resetn)
			!cfg_q.input_overcurrent_en && !cfg_q.discharge_overcurrent_en |=> !converter_off;
	endproperty
	a_off_cause: assert property (p_off_cause) else $error("converter off while disabled");

	property p_ac_off;
		@(posedge ref_clk) disable iff (!resetn)
			cfg_q.input_overcurrent_en && ac_trip |=> converter_off;
	endproperty
	a_ac_off: assert property (p_ac_off) else $error("input trip missed");

	c_to_relax: cover property (@(posedge ref_clk) disable iff (!resetn)
		burst_overload ##1 burst_relax);
	c_to_ovld: cover property (@(posedge ref_clk) disable iff (!resetn)
		burst_relax ##1 burst_overload);
	c_conv_off: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(converter_off));
	c_host_clear: cover property (@(posedge ref_clk) disable iff (!resetn)
		burst_relax && clr_relax);
	c_removal: cover property (@(posedge ref_clk) disable iff (!resetn) removal);

endmodule : charger_option_two_control

/* File: hw/oc_blanker.sv */
`timescale 1ns/1ps
module oc_blanker
	import opt2_pkg::*;
#(
	parameter int unsigned HOLD = BLANK_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic oc_in,
	output logic      trip
);
	localparam int unsigned W = $clog2(HOLD + 1);
	localparam logic [W-1:0] FULL = W'(HOLD);

	logic [W-1:0] cnt_q;

	// Any drop of the event restarts blanking, so short spikes never trip.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) cnt_q <= '0;
		else if (!oc_in) cnt_q <= '0;
		else if (cnt_q != FULL) cnt_q <= cnt_q + W'(1);
	end

	assign trip = oc_in && (cnt_q == FULL);

	property p_blank_drop;
		@(posedge ref_clk) disable iff (!resetn) !oc_in |=> !trip;
	endproperty
	a_blank_drop: assert property (p_blank_drop) else $error("trip without held event");
endmodule : oc_blanker

/* File: hw/opt2_pkg.sv */
package opt2_pkg;

	// Register location and value after power-on.
	localparam logic [7:0]  OPT2_ADDR  = 8'h31;
	localparam logic [15:0] OPT2_RESET = 16'h02b7;
	localparam int unsigned LIMIT_W    = 7;

	// Timing base. Burst intervals are counted in ticks of TICK_US.
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
	localparam int unsigned US_PER_MS    = 1000;
	localparam int unsigned TICK_US      = 100;
	localparam int unsigned TICK_CYCLES  = CYC_PER_US * TICK_US;
	localparam int unsigned BLANK_US     = 100;
	localparam int unsigned BLANK_CYCLES = CYC_PER_US * BLANK_US;

	localparam int unsigned OVLD_MS_0  = 1;
	localparam int unsigned OVLD_MS_1  = 2;
	localparam int unsigned OVLD_MS_2  = 10;
	localparam int unsigned OVLD_MS_3  = 20;
	localparam int unsigned CYCLE_MS_0 = 5;
	localparam int unsigned CYCLE_MS_1 = 10;
	localparam int unsigned CYCLE_MS_2 = 20;
	localparam int unsigned CYCLE_MS_3 = 40;

	typedef logic [8:0] tick_t;
	typedef logic [LIMIT_W-1:0] limit_t;

	typedef enum logic [1:0] {
		BURST_IDLE  = 2'b00,
		BURST_OVLD  = 2'b01,
		BURST_RELAX = 2'b10
	} burst_e;

	typedef struct packed {
		logic [1:0] overload_time_sel;
		logic       burst_on_input_overshoot_en;
		logic       burst_on_rail_sag_en;
		logic       overload_cycle_flag;
		logic       relax_cycle_flag;
		logic [1:0] burst_cycle_period_sel;
		logic       pin_limit_select;
		logic       monitor_direction_sel;
		logic       low_switch_trip_sel;
		logic       input_trip_sel;
		logic       input_overcurrent_en;
		logic       input_overcurrent_level;
		logic       discharge_overcurrent_en;
		logic       discharge_overcurrent_level;
	} opt2_s;

	function automatic tick_t ms_to_ticks(input int unsigned ms);
		ms_to_ticks = tick_t'(ms * US_PER_MS / TICK_US);
	endfunction : ms_to_ticks

	function automatic tick_t ovld_ticks(input logic [1:0] sel);
		unique case (sel)
			2'b00: ovld_ticks = ms_to_ticks(OVLD_MS_0);
			2'b01: ovld_ticks = ms_to_ticks(OVLD_MS_1);
			2'b10: ovld_ticks = ms_to_ticks(OVLD_MS_2);
			2'b11: ovld_ticks = ms_to_ticks(OVLD_MS_3);
		endcase
	endfunction : ovld_ticks

	function automatic tick_t cycle_ticks(input logic [1:0] sel);
		unique case (sel)
			2'b00: cycle_ticks = ms_to_ticks(CYCLE_MS_0);
			2'b01: cycle_ticks = ms_to_ticks(CYCLE_MS_1);
			2'b10: cycle_ticks = ms_to_ticks(CYCLE_MS_2);
			2'b11: cycle_ticks = ms_to_ticks(CYCLE_MS_3);
		endcase
	endfunction : cycle_ticks

endpackage : opt2_pkg

/* File: hw/tick_gen.sv */
`timescale 1ns/1ps
module tick_gen
	import opt2_pkg::*;
#(
	parameter int unsigned PERIOD = TICK_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic restart,
	output logic      tick
);
	localparam int unsigned W = $clog2(PERIOD + 1);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);

	logic [W-1:0] cnt_q;
	wire          wrap = (cnt_q == LAST);

	// Restart realigns the tick so each interval is exact to the cycle.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) cnt_q <= '0;
		else if (restart || wrap) cnt_q <= '0;
		else cnt_q <= cnt_q + W'(1);
	end

	// Tick looks at the count alone, because the sequencer builds restart from tick.
	assign tick = wrap;
endmodule : tick_gen

/* File: verif/host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the command-code/word port, as left after bus decode.
module host_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] reg_rdata,
	output logic      [7:0]  reg_addr  = 8'h00,
	output logic             reg_wr    = 1'b0,
	output logic             reg_rd    = 1'b0,
	output logic      [15:0] reg_wdata = 16'h0000
);
	// Strobes last one cycle; the address and data stay put until the next request.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd
endmodule : host_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
	import opt2_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic [7:0]  reg_addr;
	logic        reg_wr, reg_rd;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic        adapter_present = 1'b1, input_overshoot = 1'b0, rail_sag = 1'b0;
	logic        input_oc_event = 1'b0, discharge_oc_event = 1'b0;
	limit_t      limit_pin = 7'h0a, limit_reg = 7'h14, input_current_limit;
	opt2_s       cfg_out;
	logic        burst_overload, burst_relax, converter_off;
	int          errors = 0, n_compared = 0, n;
	always #4 ref_clk = ~ref_clk;
	// Short tick and blanking counts keep the burst intervals to a few hundred cycles.
	charger_option_two_control #(.TICK_CYCLES_P(4), .BLANK_CYCLES_P(8))
	charger_option_two_control_inst (.ref_clk(ref_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .adapter_present(adapter_present),
		.input_overshoot(input_overshoot), .rail_sag(rail_sag),
		.input_oc_event(input_oc_event), .discharge_oc_event(discharge_oc_event),
		.limit_pin(limit_pin), .limit_reg(limit_reg),
		.input_current_limit(input_current_limit), .cfg_out(cfg_out),
		.burst_overload(burst_overload), .burst_relax(burst_relax),
		.converter_off(converter_off));
	host_model host_model_inst (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc
	task automatic wait_ovld;
		int k;
		k = 0;
		while (burst_overload !== 1'b1 && k < 50) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 50) begin
			errors++;
			finish_test();
		end
	endtask : wait_ovld
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		host_model_inst.rd(8'h31, v);
		`CHK("reset value", 16'h02b7, v)
		`CHK("cfg_out reset", 16'h02b7, 16'(cfg_out))
		host_model_inst.wr(8'h31, 16'hffff);
		host_model_inst.wr(8'h30, 16'h0000);
		host_model_inst.rd(8'h31, v);
		`CHK("all ones", 16'hf3ff, v)
		`CHK("cfg_out", 16'hf3ff, 16'(cfg_out))
		host_model_inst.rd(8'h30, v);
		`CHK("unmapped", 16'h0000, v)
		$display("test regs done");
	endtask : t_regs
	task automatic t_limit;
		host_model_inst.wr(8'h31, 16'h0080);
		cyc(3);
		`CHK("lower of pin", 7'h0a, input_current_limit)
		host_model_inst.wr(8'h31, 16'h0000);
		cyc(3);
		`CHK("register only", 7'h14, input_current_limit)
		$display("test limit done");
	endtask : t_limit
	task automatic t_burst;
		host_model_inst.wr(8'h31, 16'h2000);
		input_overshoot <= 1'b1;
		wait_ovld();
		n = 0;
		while (burst_overload === 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("overload len", 40, n)
		`CHK("relax on", 1'b1, burst_relax)
		n = 0;
		while (burst_relax === 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("relax len", 160, n)
		`CHK("overload again", 1'b1, burst_overload)
		n = 0;
		while (burst_overload === 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("second overload len", 40, n)
		@(posedge ref_clk);
		input_overshoot <= 1'b0;
		cyc(20);
		`CHK("relax held", 1'b1, burst_relax)
		// The host leaves relaxation early by writing zero to its flag.
		host_model_inst.wr(8'h31, 16'h2000);
		cyc(2);
		`CHK("relax cleared", 1'b0, burst_relax)
		$display("test burst done");
	endtask : t_burst
	task automatic t_rail;
		host_model_inst.wr(8'h31, 16'hd000);
		rail_sag <= 1'b1;
		wait_ovld();
		n = 0;
		repeat (900) begin
			@(negedge ref_clk);
			if (burst_relax !== 1'b0) n++;
		end
		`CHK("no relax", 0, n)
		host_model_inst.rd(8'h31, v);
		`CHK("overload flag", 16'hd800, v)
		@(posedge ref_clk);
		rail_sag <= 1'b0;
		host_model_inst.wr(8'h31, 16'hd000);
		cyc(2);
		`CHK("overload cleared", 1'b0, burst_overload)
		host_model_inst.wr(8'h31, 16'hc000);
		rail_sag <= 1'b1;
		cyc(10);
		`CHK("both off", 1'b0, burst_overload)
		host_model_inst.wr(8'h31, 16'h3000);
		rail_sag        <= 1'b0;
		adapter_present <= 1'b0;
		cyc(3);
		host_model_inst.rd(8'h31, v);
		`CHK("removal", 16'h0000, v)
		@(posedge ref_clk);
		adapter_present <= 1'b1;
		$display("test rail done");
	endtask : t_rail
	task automatic t_protect;
		host_model_inst.wr(8'h31, 16'h0008);
		input_oc_event <= 1'b1;
		cyc(8);
		`CHK("blanked", 1'b0, converter_off)
		cyc(6);
		`CHK("input trip", 1'b1, converter_off)
		@(posedge ref_clk);
		input_oc_event <= 1'b0;
		cyc(3);
		`CHK("input release", 1'b0, converter_off)
		host_model_inst.wr(8'h31, 16'h0002);
		discharge_oc_event <= 1'b1;
		cyc(3);
		`CHK("discharge trip", 1'b1, converter_off)
		host_model_inst.wr(8'h31, 16'h0000);
		cyc(3);
		`CHK("discharge off", 1'b0, converter_off)
		@(posedge ref_clk);
		discharge_oc_event <= 1'b0;
		$display("test protect done");
	endtask : t_protect
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_limit();
		t_burst();
		t_rail();
		t_protect();
		finish_test();
	end
endmodule : tb
